// file: bench/pcg_pin_model.sv
// Purpose: Far-side pins seen by the port C block
// Assumes: Pull devices pull up
// Notes:   Undriven floating pins toggle each cycle
`timescale 1ns/1ns

module pcg_pin_model (
  input  wire logic       clk_i,
  input  wire logic [3:0] pin_o,
  input  wire logic [3:0] pin_oe_o,
  input  wire logic [3:0] pull_en_o,
  input  wire logic       ext_en_i,
  input  wire logic [3:0] ext_val_i,
  output logic      [3:0] level_o
);
  logic float_reg = 1'b0;
  // Floating level, never a stable guess
  always_ff @(posedge clk_i) begin
    float_reg <= ~float_reg;
  end
  // driver wins, else external value, then pull, then float
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      level_o[k] = pin_oe_o[k] ? pin_o[k] : ext_en_i ? ext_val_i[k] :
                   pull_en_o[k] ? 1'b1 : float_reg ^ k[0];
    end
  end
endmodule

// file: bench/pcg_port_monitor.sv
// Purpose: Port-level checks for the port C gang block
// Assumes: One clock, sync active-high reset
// Notes:   Bound into every pcg_port instance
`timescale 1ns/1ns

module pcg_port_mon #(
  parameter int PINS = 4
) (
  input wire logic            clk_i,
  input wire logic            rst_i,
  input wire logic            ce_i,
  input wire logic            cyc_i,
  input wire logic            stb_i,
  input wire logic            ack_o,
  input wire logic [PINS-1:0] pin_o,
  input wire logic [PINS-1:0] pin_oe_o,
  input wire logic [PINS-1:0] pull_en_o,
  input wire logic [PINS-1:0] slew_en_o,
  input wire logic [PINS-1:0] drive_high_o,
  input wire logic [7:1]      gang_member_o,
  input wire logic            gang_data_o,
  input wire logic            gang_slew_o,
  input wire logic            gang_drive_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // Bus answer and pin relations
  // ----------------------------------------
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o && ce_i |=> ack_o)
    else $error("request not answered");
  a_ack_pulse: assert property (ack_o && ce_i |=> !ack_o)
    else $error("ack longer than one cycle");
  a_reset_clears: assert property ($fell(rst_i) |-> !pin_oe_o && !pin_o)
    else $error("pins not idle after reset");
  a_slew_gated: assert property (!(slew_en_o & ~pin_oe_o))
    else $error("slew on an input pin");
  a_drive_gated: assert property (!(drive_high_o & ~pin_oe_o))
    else $error("high drive on an input pin");
  a_pin_undriven: assert property (!(pin_o & ~pin_oe_o))
    else $error("level on an input pin");
  a_gang_copy: assert property (
    !(gang_member_o[3:1] & (pin_o[3:1] ^ {3{gang_data_o}})))
    else $error("ganged pin data differs");
  a_gang_setting: assert property (
    !(gang_member_o[3:1] & ((slew_en_o[3:1] ^ {3{gang_slew_o}})
      | (drive_high_o[3:1] ^ {3{gang_drive_o}}))))
    else $error("ganged pin setting differs");
  a_pin0_forced: assert property (
    gang_member_o != 7'h00 |-> pin_oe_o[0] && pin_o[0] == gang_data_o)
    else $error("pin zero not output in gang");
  a_gang_locked: assert property (gang_member_o != 7'h00 |=> $stable(gang_member_o))
    else $error("gang select changed");
  c_ack: cover property (ack_o);
  c_gang: cover property (gang_member_o != 7'h00);
  c_out: cover property (pin_oe_o == 4'hf);
endmodule

bind pcg_port pcg_port_mon #(.PINS(PINS)) mon_u (.*);

// file: bench/pcg_port_tb_top.sv
// Purpose: Self-checking bench for the port C gang block
// Assumes: Wishbone answer after a taken request
// Notes:   Each scenario task judges its own results
`timescale 1ns/1ns
`include "pcg_regs.svh"

module pcg_port_tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ext_en = 1'b1;
  logic [5:0] adr_i = 6'h00;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic [3:0] sel_i = 4'hf, ext_val = 4'h0, pin_i, pin_o, pin_oe_o;
  logic [3:0] pull_en_o, slew_en_o, drive_high_o;
  logic [7:1] gang_member_o;
  logic ack_o, gang_data_o, gang_slew_o, gang_drive_o;
  int error_cnt = 0;
  int checks = 0;
  pcg_port dut_u (.*);
  pcg_pin_model pins_u (.clk_i(clk_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
    .pull_en_o(pull_en_o), .ext_en_i(ext_en), .ext_val_i(ext_val),
    .level_o(pin_i));
  // Clock
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // Bus cycle and compare
  // ----------------------------------------
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 20) error_cnt++;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reset_dut();
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_and_data();
    ext_val <= 4'ha;
    chk({pull_en_o, pin_oe_o, pin_o}, 32'h0);
    bus(1'b1, `PCG_OFF_DATA, 32'h9);
    bus(1'b0, `PCG_OFF_DATA, 32'h0);
    chk(rd, 32'ha);
    bus(1'b1, `PCG_OFF_DIR, 32'hf);
    chk({pin_oe_o, pin_o}, 32'hf9);
    bus(1'b0, `PCG_OFF_DATA, 32'h0);
    chk(rd, 32'h9);
  endtask
  task automatic t_slew_drive();
    bus(1'b1, `PCG_OFF_DIR, 32'h5);
    bus(1'b1, `PCG_OFF_SLEW, 32'hf);
    bus(1'b1, `PCG_OFF_DRIVE, 32'h6);
    chk(slew_en_o, 32'h5);
    chk(drive_high_o, 32'h4);
    bus(1'b1, `PCG_OFF_PULL, 32'hf);
    chk(pull_en_o, 32'ha);
    bus(1'b0, 6'h3c, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic t_gang();
    bus(1'b1, `PCG_OFF_DIR, 32'h0);
    bus(1'b1, `PCG_OFF_DATA, 32'h1);
    bus(1'b1, `PCG_OFF_SLEW, 32'h1);
    bus(1'b1, `PCG_OFF_DRIVE, 32'h0);
    bus(1'b1, `PCG_OFF_GANG, 32'h5);
    chk({gang_member_o, pin_oe_o}, {21'h0, 7'h02, 4'h5});
    chk({slew_en_o, pin_o}, 32'h55);
    bus(1'b1, `PCG_OFF_GANG, 32'hff);
    bus(1'b0, `PCG_OFF_GANG, 32'h0);
    chk(rd, 32'h5);
    bus(1'b1, `PCG_OFF_DATA, 32'h0);
    chk(pin_o, 32'h0);
  endtask
  task automatic t_gang_off();
    reset_dut();
    bus(1'b1, `PCG_OFF_GANG, 32'hfe);
    chk({gang_member_o, pin_oe_o}, 32'h0);
    bus(1'b0, `PCG_OFF_GANG, 32'h0);
    chk(rd, 32'hfe);
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Main sequence
  initial begin
    reset_dut();
    t_reset_and_data();
    t_slew_drive();
    t_gang();
    t_gang_off();
    end_of_test();
  end
  // Watchdog
  initial begin
    #50000;
    error_cnt++;
    end_of_test();
  end
endmodule

// file: common/pcg_pkg.sv
// Purpose: Types shared by the port C gang block
// Assumes: Four-pin port
// Notes:   Constants live in pcg_regs.svh
package pcg_pkg;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    PCG_IDLE = 2'b01,
    PCG_ACK  = 2'b10
  } pcg_bus_state_type;

endpackage

// file: common/pcg_regs.svh
// Purpose: Offsets, field positions, reset values for the port C gang block
// Assumes: Word-aligned Wishbone slave, byte addresses
// Notes:   Included by bare name
`ifndef PCG_REGS_SVH
`define PCG_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PCG_OFF_DATA      6'h00
`define PCG_OFF_DIR       6'h04
`define PCG_OFF_PULL      6'h08
`define PCG_OFF_SLEW      6'h0c
`define PCG_OFF_DRIVE     6'h10
`define PCG_OFF_GANG      6'h14

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define PCG_GANG_EN_BIT   0
`define PCG_GANG_SEL_LSB  1
`define PCG_GANG_SEL_MSB  7
`define PCG_RST_PORT      4'h0
`define PCG_RST_GANG      8'h00

`endif

// file: core/pcg_port.sv
// Purpose: Four-pin port C with slew, drive and ganged output control
// Assumes: Classic Wishbone slave, pins synchronous to clk_i
// Notes:   Gang pins beyond the four local ones leave as gang outputs
`timescale 1ns/1ns
`include "pcg_regs.svh"

module pcg_port #(
  parameter int PINS = 4
) (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic            ce_i,
  input  wire logic [5:0]      adr_i,
  input  wire logic [31:0]     dat_i,
  output logic      [31:0]     dat_o,
  input  wire logic            we_i,
  input  wire logic [3:0]      sel_i,
  input  wire logic            cyc_i,
  input  wire logic            stb_i,
  output logic                 ack_o,
  input  wire logic [PINS-1:0] pin_i,
  output logic      [PINS-1:0] pin_o,
  output logic      [PINS-1:0] pin_oe_o,
  output logic      [PINS-1:0] pull_en_o,
  output logic      [PINS-1:0] slew_en_o,
  output logic      [PINS-1:0] drive_high_o,
  output logic      [7:1]      gang_member_o,
  output logic                 gang_data_o,
  output logic                 gang_slew_o,
  output logic                 gang_drive_o
);

  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  initial begin
    if (PINS < 1 || PINS > 8) begin
      $error("pcg_port: PINS must be 1 to 8");
    end
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    pcg_pkg::pcg_bus_state_type bus;
    logic [PINS-1:0]            data;
    logic [PINS-1:0]            dir;
    logic [PINS-1:0]            pull;
    logic [PINS-1:0]            slew;
    logic [PINS-1:0]            drive;
    logic [31:0]                rdata;
  } pcg_state_type;

  pcg_state_type state_reg;
  pcg_state_type state_next;

  logic       req;
  logic       wr_lane0;
  logic       gang_wr;
  logic [7:0] gang_val;
  logic       gang_en;
  logic [7:1] gang_sel;

  // Effective pin settings; eff_dir is also read by the data read mux below
  logic [PINS-1:0] eff_dir;
  logic [PINS-1:0] member;
  logic [PINS-1:0] eff_data;
  logic [PINS-1:0] eff_slew;
  logic [PINS-1:0] eff_drive;

  // Bus request and low-lane write
  assign req      = cyc_i && stb_i;
  assign wr_lane0 = req && we_i && sel_i[0]
                    && state_reg.bus == pcg_pkg::PCG_IDLE;
  assign gang_wr  = wr_lane0 && adr_i == `PCG_OFF_GANG;

  pcg_wo_reg #(
    .WIDTH    (8)
  ) u_gang (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .wr_i     (gang_wr),
    .wdata_i  (dat_i[7:0]),
    .value_o  (gang_val),
    .locked_o ()
  );

  assign gang_en  = gang_val[`PCG_GANG_EN_BIT];
  assign gang_sel = gang_val[`PCG_GANG_SEL_MSB:`PCG_GANG_SEL_LSB];

  // Zero-extend a port field to a bus word
  function automatic logic [31:0] pcg_word(input logic [PINS-1:0] v);
    pcg_word = 32'h0000_0000;
    pcg_word[PINS-1:0] = v;
  endfunction

  // Bus handshake, register writes and read mux
  always_comb begin
    state_next = state_reg;
    case (state_reg.bus)
      pcg_pkg::PCG_IDLE: begin
        if (req) begin
          state_next.bus = pcg_pkg::PCG_ACK;
          if (adr_i == `PCG_OFF_DATA) begin
            state_next.rdata = pcg_word((state_reg.data & eff_dir)
                                        | (pin_i & ~eff_dir));
          end else if (adr_i == `PCG_OFF_DIR) begin
            state_next.rdata = pcg_word(state_reg.dir);
          end else if (adr_i == `PCG_OFF_PULL) begin
            state_next.rdata = pcg_word(state_reg.pull);
          end else if (adr_i == `PCG_OFF_SLEW) begin
            state_next.rdata = pcg_word(state_reg.slew);
          end else if (adr_i == `PCG_OFF_DRIVE) begin
            state_next.rdata = pcg_word(state_reg.drive);
          end else if (adr_i == `PCG_OFF_GANG) begin
            state_next.rdata = {24'h000000, gang_val};
          end else begin
            state_next.rdata = 32'h0000_0000;
          end
          if (wr_lane0) begin
            if (adr_i == `PCG_OFF_DATA) begin
              state_next.data = dat_i[PINS-1:0];
            end else if (adr_i == `PCG_OFF_DIR) begin
              state_next.dir = dat_i[PINS-1:0];
            end else if (adr_i == `PCG_OFF_PULL) begin
              state_next.pull = dat_i[PINS-1:0];
            end else if (adr_i == `PCG_OFF_SLEW) begin
              state_next.slew = dat_i[PINS-1:0];
            end else if (adr_i == `PCG_OFF_DRIVE) begin
              state_next.drive = dat_i[PINS-1:0];
            end
          end
        end
      end
      pcg_pkg::PCG_ACK: begin
        state_next.bus = pcg_pkg::PCG_IDLE;
      end
      default: begin
        state_next.bus = pcg_pkg::PCG_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg.bus   <= pcg_pkg::PCG_IDLE;
      state_reg.data  <= PINS'(`PCG_RST_PORT);
      state_reg.dir   <= PINS'(`PCG_RST_PORT);
      state_reg.pull  <= PINS'(`PCG_RST_PORT);
      state_reg.slew  <= PINS'(`PCG_RST_PORT);
      state_reg.drive <= PINS'(`PCG_RST_PORT);
      state_reg.rdata <= 32'h0000_0000;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // Pin control
  // ----------------------------------------

  // Gang membership and effective settings
  always_comb begin
    member = '0;
    for (int i = 1; i < PINS; i++) begin
      member[i] = gang_en && gang_sel[i];
    end
    eff_dir = state_reg.dir;
    if (gang_en) begin
      eff_dir[0] = 1'b1;
    end
    eff_data  = state_reg.data;
    eff_slew  = state_reg.slew;
    eff_drive = state_reg.drive;
    for (int i = 1; i < PINS; i++) begin
      if (member[i]) begin
        eff_dir[i]   = 1'b1;
        eff_data[i]  = state_reg.data[0];
        eff_slew[i]  = state_reg.slew[0];
        eff_drive[i] = state_reg.drive[0];
      end
    end
  end

  assign pin_oe_o     = eff_dir;
  assign pin_o        = eff_data & eff_dir;
  // Pulls only on inputs
  assign pull_en_o    = state_reg.pull & ~eff_dir;
  assign slew_en_o    = eff_slew & eff_dir;
  assign drive_high_o = eff_drive & eff_dir;

  // Gang outputs: member select for all pins 1 to 7, this port's included, plus pin 0 settings
  assign gang_member_o = gang_en ? gang_sel : 7'h00;
  assign gang_data_o   = state_reg.data[0];
  assign gang_slew_o   = state_reg.slew[0];
  assign gang_drive_o  = state_reg.drive[0];

  assign ack_o = state_reg.bus == pcg_pkg::PCG_ACK;
  assign dat_o = state_reg.rdata;

endmodule

// file: core/pcg_wo_reg.sv
// Purpose: Write-once control register, locked after first write
// Assumes: Synchronous active-high reset
// Notes:   Read data comes out of the register itself
`timescale 1ns/1ns
`include "pcg_regs.svh"

module pcg_wo_reg #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             wr_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  output logic      [WIDTH-1:0] value_o,
  output logic                  locked_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0] value;
    logic             locked;
  } pcg_wo_state_type;

  pcg_wo_state_type state_reg;
  pcg_wo_state_type state_next;

  initial begin
    if (WIDTH < 1) begin
      $error("pcg_wo_reg: WIDTH must be at least one");
    end
  end

  // Capture on first write, then hold
  always_comb begin
    state_next = state_reg;
    if (wr_i && !state_reg.locked) begin
      state_next.value  = wdata_i;
      state_next.locked = 1'b1;
    end
  end

  // Register with clock enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg.value  <= WIDTH'(`PCG_RST_GANG);
      state_reg.locked <= 1'b0;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  assign value_o  = state_reg.value;
  assign locked_o = state_reg.locked;

endmodule
